// *** src/lgp_pkg.sv ***
// Package for the shared LCD / general-purpose I/O ports C, D and E.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package lgp_pkg;

  // ****************************************************************
  // Register indices and address width
  // ****************************************************************
  localparam logic [7:0] LGP_IDX_PORT_C_DATA = 8'h02;
  localparam logic [7:0] LGP_IDX_PORT_D_DATA = 8'h03;
  localparam logic [7:0] LGP_IDX_PORT_E_DATA = 8'h09;
  localparam logic [7:0] LGP_IDX_PORT_C_DIR = 8'h06;
  localparam logic [7:0] LGP_IDX_PORT_D_DIR = 8'h07;
  localparam logic [7:0] LGP_IDX_PORT_E_DIR = 8'h0a;
  localparam logic [7:0] LGP_IDX_LCD_CFG = 8'h10;
  localparam int LGP_ADDR_W = 12;

  // ****************************************************************
  // Field positions of the LCD routing register
  // ****************************************************************
  localparam int LGP_BIT_C_LOWER = 0;
  localparam int LGP_BIT_C_UPPER = 1;
  localparam int LGP_BIT_D = 2;
  localparam int LGP_BIT_E = 3;
  localparam int LGP_BIT_DISP_EN = 4;
  localparam int LGP_CFG_W = 5;

  // ****************************************************************
  // Reset values and port-C frontplane mask
  // ****************************************************************
  localparam logic [7:0] LGP_DIR_RESET = 8'h00;
  localparam logic [LGP_CFG_W-1:0] LGP_CFG_RESET = 5'h00;
  localparam logic [7:0] LGP_C_UPPER_MASK = 8'h30;
  localparam logic [7:0] LGP_C_LOWER_MASK = 8'h0f;

  // Bus state machine
  typedef enum logic [1:0] {
    LGP_IDLE = 2'b01,
    LGP_ACCESS = 2'b10
  } lgp_bus_state_t;

endpackage

// *** src/lgp_sync2.sv ***
// Two-flop synchroniser for the 24 pin levels.
// Assumes pin inputs are asynchronous to pclk.
`timescale 1ns/10ps
module lgp_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [23:0] d,
  output logic [23:0] q
);
  typedef struct packed {
    logic [23:0] meta_r;
    logic [23:0] sync_r;
  } lgp_sync_state_t;

  lgp_sync_state_t st_r;
  lgp_sync_state_t st_nxt;

  // Shift the pin level through two stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta_r = d;
    st_nxt.sync_r = st_r.meta_r;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.sync_r;
endmodule

// *** src/lgp_ports.sv ***
// Ports C, D and E: data latches, direction bits, pin read-back and
// LCD frontplane takeover, reached as an APB slave.
// Assumes a 25 MHz pclk, asynchronous pins, and an LCD driver that
// supplies frontplane levels.
//
// Summary of operation
// - Port C latch, untouched by reset
// - Port C direction: 1 output, reset clears
// - Port C read: latch if output, else pin
// - Data writes with pstrb[0] set always update latch
// - Port C frontplane groups under two enables
// - Port D latch, untouched by reset
// - Port D direction: 1 output, reset clears
// - Port D read: latch if output, else pin
// - Port D frontplanes when selected and enabled
// - Port E latch, untouched by reset
// - Port E direction: 1 output, reset clears
// - Port E read: latch if output, else pin
// - Port E frontplanes when selected and enabled
`timescale 1ns/10ps
module lgp_ports
  import lgp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lgp_pkg::LGP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_c_in,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  input wire logic [7:0] port_d_in,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_oe,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe,
  input wire logic [24:3] frontplane_output,
  output logic display_driver_enable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    lgp_bus_state_t bus_r;
    logic [7:0] port_c_direction_r;
    logic [7:0] port_d_direction_r;
    logic [7:0] port_e_direction_r;
    logic [LGP_CFG_W-1:0] cfg_r;
    logic [31:0] rdata_r;
    logic err_r;
  } lgp_state_t;

  lgp_state_t st_r;
  lgp_state_t st_nxt;
  // Latches live outside the reset domain since reset leaves them alone
  logic [7:0] port_c_data_r;
  logic [7:0] port_d_data_r;
  logic [7:0] port_e_data_r;
  logic [23:0] pins_sync;
  logic [7:0] c_pin;
  logic [7:0] d_pin;
  logic [7:0] e_pin;
  logic [7:0] c_lcd;
  logic [7:0] d_lcd;
  logic [7:0] e_lcd;
  logic [7:0] idx;
  logic addr_ok;
  logic wr_go;
  logic wr_byte;

  // Byte address bits 9:2 to register index; misaligned or out-of-range is refused by addr_ok
  function automatic logic [7:0] addr_idx(input logic [LGP_ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // Per-bit read-back: latch where output, synchronised pin where input
  function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] lat,
                                          input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  // ****************************************************************
  // Pin input synchronisation
  // ****************************************************************
  lgp_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({port_e_in, port_d_in, port_c_in}),
    .q(pins_sync)
  );
  assign c_pin = pins_sync[7:0];
  assign d_pin = pins_sync[15:8];
  assign e_pin = pins_sync[23:16];

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign idx = addr_idx(paddr);
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[LGP_ADDR_W-1:10] == '0) &&
                   (idx == LGP_IDX_PORT_C_DATA || idx == LGP_IDX_PORT_D_DATA ||
                    idx == LGP_IDX_PORT_E_DATA || idx == LGP_IDX_PORT_C_DIR ||
                    idx == LGP_IDX_PORT_D_DIR || idx == LGP_IDX_PORT_E_DIR ||
                    idx == LGP_IDX_LCD_CFG);
  assign wr_go = psel && penable && pready && pwrite && addr_ok;
  assign wr_byte = wr_go && pstrb[0];

  // ****************************************************************
  // LCD frontplane selection
  // ****************************************************************
  assign display_driver_enable = st_r.cfg_r[LGP_BIT_DISP_EN];
  assign c_lcd = ({8{display_driver_enable && st_r.cfg_r[LGP_BIT_C_UPPER]}} &
                  LGP_C_UPPER_MASK) |
                 ({8{display_driver_enable && st_r.cfg_r[LGP_BIT_C_LOWER]}} &
                  LGP_C_LOWER_MASK);
  assign d_lcd = {8{display_driver_enable && st_r.cfg_r[LGP_BIT_D]}};
  assign e_lcd = {8{display_driver_enable && st_r.cfg_r[LGP_BIT_E]}};

  // Frontplane takes the pin and forces the buffer on
  always_comb begin
    port_c_out = (c_lcd & {2'b00, frontplane_output[24:19]}) |
                 (~c_lcd & port_c_data_r);
    port_c_oe = c_lcd | st_r.port_c_direction_r;
    port_d_out = (d_lcd & frontplane_output[18:11]) | (~d_lcd & port_d_data_r);
    port_d_oe = d_lcd | st_r.port_d_direction_r;
    port_e_out = (e_lcd & frontplane_output[10:3]) | (~e_lcd & port_e_data_r);
    port_e_oe = e_lcd | st_r.port_e_direction_r;
  end

  // ****************************************************************
  // Data latches, no reset
  // ****************************************************************
  // Latch takes every data write with pstrb[0] set, whatever the direction
  always_ff @(posedge pclk) begin
    if (wr_byte && idx == LGP_IDX_PORT_C_DATA) begin
      port_c_data_r <= pwdata[7:0];
    end
    if (wr_byte && idx == LGP_IDX_PORT_D_DATA) begin
      port_d_data_r <= pwdata[7:0];
    end
    if (wr_byte && idx == LGP_IDX_PORT_E_DATA) begin
      port_e_data_r <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // APB slave and control registers
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.bus_r)
      LGP_IDLE: begin
        if (psel && !penable) begin
          st_nxt.bus_r = LGP_ACCESS;
          st_nxt.err_r = !addr_ok;
          st_nxt.rdata_r = '0;
          unique case (idx)
            LGP_IDX_PORT_C_DATA: st_nxt.rdata_r[7:0] =
              pin_view(st_r.port_c_direction_r, port_c_data_r, c_pin);
            LGP_IDX_PORT_D_DATA: st_nxt.rdata_r[7:0] =
              pin_view(st_r.port_d_direction_r, port_d_data_r, d_pin);
            LGP_IDX_PORT_E_DATA: st_nxt.rdata_r[7:0] =
              pin_view(st_r.port_e_direction_r, port_e_data_r, e_pin);
            LGP_IDX_PORT_C_DIR: st_nxt.rdata_r[7:0] = st_r.port_c_direction_r;
            LGP_IDX_PORT_D_DIR: st_nxt.rdata_r[7:0] = st_r.port_d_direction_r;
            LGP_IDX_PORT_E_DIR: st_nxt.rdata_r[7:0] = st_r.port_e_direction_r;
            LGP_IDX_LCD_CFG: st_nxt.rdata_r[LGP_CFG_W-1:0] = st_r.cfg_r;
            default: st_nxt.rdata_r = '0;
          endcase
          if (!addr_ok) begin
            st_nxt.rdata_r = '0;
          end
        end
      end
      LGP_ACCESS: begin
        st_nxt.bus_r = LGP_IDLE;
        if (wr_byte) begin
          if (idx == LGP_IDX_PORT_C_DIR) begin
            st_nxt.port_c_direction_r = pwdata[7:0];
          end
          if (idx == LGP_IDX_PORT_D_DIR) begin
            st_nxt.port_d_direction_r = pwdata[7:0];
          end
          if (idx == LGP_IDX_PORT_E_DIR) begin
            st_nxt.port_e_direction_r = pwdata[7:0];
          end
          if (idx == LGP_IDX_LCD_CFG) begin
            st_nxt.cfg_r = pwdata[LGP_CFG_W-1:0];
          end
        end
      end
      default: st_nxt.bus_r = LGP_IDLE;
    endcase
  end

  // State register; direction bits clear to input on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.bus_r <= LGP_IDLE;
      st_r.port_c_direction_r <= LGP_DIR_RESET;
      st_r.port_d_direction_r <= LGP_DIR_RESET;
      st_r.port_e_direction_r <= LGP_DIR_RESET;
      st_r.cfg_r <= LGP_CFG_RESET;
      st_r.rdata_r <= '0;
      st_r.err_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Answer in the access phase, one cycle after setup
  assign pready = (st_r.bus_r == LGP_ACCESS);
  assign pslverr = pready && st_r.err_r;
  assign prdata = pready ? st_r.rdata_r : 32'h0000_0000;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Register writes land at the access edge
  a_dir_c_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && pready && idx == LGP_IDX_PORT_C_DIR) |=> (st_r.port_c_direction_r ==
    $past(pwdata[7:0]))) else $error("port c direction not written");
  a_dir_d_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && pready && idx == LGP_IDX_PORT_D_DIR) |=> (st_r.port_d_direction_r ==
    $past(pwdata[7:0]))) else $error("port d direction not written");
  a_dir_e_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && pready && idx == LGP_IDX_PORT_E_DIR) |=> (st_r.port_e_direction_r ==
    $past(pwdata[7:0]))) else $error("port e direction not written");
  a_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && idx == LGP_IDX_PORT_C_DATA) |=> (port_c_data_r == $past(pwdata[7:0])))
    else $error("port c latch missed a write");
  a_latch_d_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && idx == LGP_IDX_PORT_D_DATA) |=> (port_d_data_r == $past(pwdata[7:0])))
    else $error("port d latch missed a write");
  a_latch_e_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_byte && idx == LGP_IDX_PORT_E_DATA) |=> (port_e_data_r == $past(pwdata[7:0])))
    else $error("port e latch missed a write");

  // Read data mixes latch and pin per direction bit
  a_read_c_view: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready && idx == LGP_IDX_PORT_C_DATA && addr_ok) |=>
    (prdata[7:0] == (($past(st_r.port_c_direction_r) & $past(port_c_data_r)) |
    (~$past(st_r.port_c_direction_r) & $past(c_pin)))))
    else $error("port c read mixes latch and pin wrongly");
  a_read_d_view: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready && idx == LGP_IDX_PORT_D_DATA && addr_ok) |=>
    (prdata[7:0] == (($past(st_r.port_d_direction_r) & $past(port_d_data_r)) |
    (~$past(st_r.port_d_direction_r) & $past(d_pin)))))
    else $error("port d read mixes latch and pin wrongly");
  a_read_e_view: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready && idx == LGP_IDX_PORT_E_DATA && addr_ok) |=>
    (prdata[7:0] == (($past(st_r.port_e_direction_r) & $past(port_e_data_r)) |
    (~$past(st_r.port_e_direction_r) & $past(e_pin)))))
    else $error("port e read mixes latch and pin wrongly");

  // Pin ownership: frontplane when selected, otherwise general I/O
  a_c_upper_lcd: assert property (@(posedge pclk) disable iff (!presetn)
    (display_driver_enable && st_r.cfg_r[LGP_BIT_C_UPPER]) |->
    (port_c_oe[5:4] == 2'b11 && port_c_out[5:4] == frontplane_output[24:23]))
    else $error("port c upper frontplane not routed");
  a_c_lower_lcd: assert property (@(posedge pclk) disable iff (!presetn)
    (display_driver_enable && st_r.cfg_r[LGP_BIT_C_LOWER]) |->
    (port_c_oe[3:0] == 4'hf && port_c_out[3:0] == frontplane_output[22:19]))
    else $error("port c lower frontplane not routed");
  a_d_lcd_route: assert property (@(posedge pclk) disable iff (!presetn)
    (display_driver_enable && st_r.cfg_r[LGP_BIT_D]) |->
    (port_d_oe == 8'hff && port_d_out == frontplane_output[18:11]))
    else $error("port d frontplane not routed");
  a_e_lcd_route: assert property (@(posedge pclk) disable iff (!presetn)
    (display_driver_enable && st_r.cfg_r[LGP_BIT_E]) |->
    (port_e_oe == 8'hff && port_e_out == frontplane_output[10:3]))
    else $error("port e frontplane not routed");
  // Latches power up unknown, so the latch path is compared case-exact
  a_d_gpio_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !(display_driver_enable && st_r.cfg_r[LGP_BIT_D]) |->
    (port_d_oe == st_r.port_d_direction_r && port_d_out === port_d_data_r))
    else $error("port d not general io");
  a_e_gpio_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !(display_driver_enable && st_r.cfg_r[LGP_BIT_E]) |->
    (port_e_oe == st_r.port_e_direction_r && port_e_out === port_e_data_r))
    else $error("port e not general io");
  a_c_low_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    !(display_driver_enable && st_r.cfg_r[LGP_BIT_C_LOWER]) |->
    (port_c_oe[3:0] == st_r.port_c_direction_r[3:0] && port_c_out[3:0] ===
    port_c_data_r[3:0])) else $error("port c lower bits not general io");
  a_c_top_gpio: assert property (@(posedge pclk) disable iff (!presetn)
    (port_c_oe[7:6] == st_r.port_c_direction_r[7:6] && port_c_out[7:6] ===
    port_c_data_r[7:6])) else $error("port c top bits not general io");

  // Bus answer: one access cycle, refused transfers read zero
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held past one cycle");
  a_refuse_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> (prdata == 32'h0000_0000)) else $error("refused transfer returned data");

endmodule

// *** verification/lgp_ports_bench.sv ***
// Self-checking bench for the shared LCD / general-purpose ports C, D, E.
// Assumes lgp_pkg is compiled first; the bench is the only APB master.
`timescale 1ns/10ps
module lcd_shared_gpio_ports_cde_bench;
  import lgp_pkg::*;
  // ********************************************************
  // Signals and bench models
  // ********************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr, dden;
  logic [7:0] pin [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] po [3];
  logic [7:0] oe [3];
  logic [24:3] fp = 22'h0;
  logic [7:0] lat [3];
  logic [7:0] dir [3];
  logic [11:0] da [3];
  logic [11:0] ra [3];
  logic [32:0] q [$];
  int fail_count = 0;
  int checks = 0;
  int seed = 32'heb44;

  always #20 pclk = ~pclk;

  lgp_ports dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_c_in(pin[0]), .port_c_out(po[0]),
    .port_c_oe(oe[0]), .port_d_in(pin[1]), .port_d_out(po[1]), .port_d_oe(oe[1]),
    .port_e_in(pin[2]), .port_e_out(po[2]), .port_e_oe(oe[2]),
    .frontplane_output(fp), .display_driver_enable(dden));

  // ********************************************************
  // Shared tasks
  // ********************************************************
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pin read-back: latch where output, pin level where input
  task automatic rd(input int i);
    apb(1'b0, da[i], 32'h0, {25'h0, (lat[i] & dir[i]) | (pin[i] & ~dir[i])});
  endtask

  // Pin drive and enable for a given routing word
  task automatic pins(input logic [4:0] cfg);
    logic [7:0] m [3];
    logic [7:0] f [3];
    // Look between edges, where the outputs have settled
    @(negedge pclk);
    m[0] = cfg[4] ? ((cfg[1] ? 8'h30 : 8'h00) | (cfg[0] ? 8'h0f : 8'h00)) : 8'h00;
    m[1] = (cfg[4] && cfg[2]) ? 8'hff : 8'h00;
    m[2] = (cfg[4] && cfg[3]) ? 8'hff : 8'h00;
    f[0] = {2'b00, fp[24:19]};
    f[1] = fp[18:11];
    f[2] = fp[10:3];
    for (int i = 0; i < 3; i++) begin
      check({25'h0, po[i]}, {25'h0, (f[i] & m[i]) | (lat[i] & ~m[i])});
      check({25'h0, oe[i]}, {25'h0, m[i] | dir[i]});
    end
    check({32'h0, dden}, {32'h0, cfg[4]});
    // Hand back on a rising edge so the next stimulus stays edge aligned
    @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ********************************************************
  // Read watcher and watchdog
  // ********************************************************
  // Compares every completed read with the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    da = '{ba(LGP_IDX_PORT_C_DATA), ba(LGP_IDX_PORT_D_DATA), ba(LGP_IDX_PORT_E_DATA)};
    ra = '{ba(LGP_IDX_PORT_C_DIR), ba(LGP_IDX_PORT_D_DIR), ba(LGP_IDX_PORT_E_DIR)};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Directions cleared by reset
    for (int i = 0; i < 3; i++) begin
      check({25'h0, oe[i]}, 33'h0);
      apb(1'b0, ra[i], 32'h0, 33'h0);
    end
    apb(1'b0, ba(LGP_IDX_LCD_CFG), 32'h0, 33'h0);
    // Random latches, directions and pins; latch written before direction
    repeat (4) begin
      for (int i = 0; i < 3; i++) begin
        lat[i] = 8'($random(seed));
        dir[i] = 8'($random(seed));
        pin[i] <= 8'($random(seed));
        apb(1'b1, da[i], {24'hffffff, lat[i]}, 33'h0);
        apb(1'b1, ra[i], {24'h0, dir[i]}, 33'h0);
        repeat (4) @(posedge pclk);
        rd(i);
        apb(1'b0, ra[i], 32'h0, {25'h0, dir[i]});
      end
      pins(5'h00);
    end
    // Latch written while input, then seen once output
    for (int i = 0; i < 3; i++) begin
      dir[i] = 8'h00;
      apb(1'b1, ra[i], 32'h0, 33'h0);
      lat[i] = ~pin[i];
      apb(1'b1, da[i], {24'h0, lat[i]}, 33'h0);
      rd(i);
      dir[i] = 8'hff;
      apb(1'b1, ra[i], 32'hff, 33'h0);
      rd(i);
      dir[i] = 8'($random(seed));
      apb(1'b1, ra[i], {24'h0, dir[i]}, 33'h0);
    end
    // Every routing word, with fresh frontplane levels
    for (int c = 0; c < 32; c++) begin
      fp <= 22'($random(seed));
      apb(1'b1, ba(LGP_IDX_LCD_CFG), c, 33'h0);
      pins(c[4:0]);
      apb(1'b0, ba(LGP_IDX_LCD_CFG), 32'h0, {1'b0, c});
    end
    apb(1'b1, ba(LGP_IDX_LCD_CFG), 32'h0, 33'h0);
    // Unmapped and misaligned places refuse; a cleared strobe writes nothing
    apb(1'b0, 12'h044, 32'h0, {1'b1, 32'h0});
    apb(1'b1, ra[0] + 12'h001, {24'h0, ~dir[0]}, 33'h0);
    apb(1'b0, ra[0] + 12'h001, 32'h0, {1'b1, 32'h0});
    pstrb <= 4'he;
    apb(1'b1, ra[0], {24'h0, ~dir[0]}, 33'h0);
    pstrb <= 4'hf;
    apb(1'b0, ra[0], 32'h0, {25'h0, dir[0]});
    // Reset in mid-run clears directions but keeps latches
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    dir = '{8'h00, 8'h00, 8'h00};
    pins(5'h00);
    for (int i = 0; i < 3; i++) begin
      dir[i] = 8'hff;
      apb(1'b1, ra[i], 32'hff, 33'h0);
      rd(i);
    end
    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule
